// ---- pkg/exec_map.svh ----
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define EXEC_DATA_W      8
`define EXEC_ADDR_W      8
`define EXEC_PC_W        11
`define EXEC_MEM_DEPTH   256
`define EXEC_WDT_PRE_W   8
`define EXEC_WDT_CNT_W   8

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define EXEC_PC_RST      11'h000
`define EXEC_WORK_RST    8'h00

`endif

// ---- pkg/exec_pkg.sv ----
`include "exec_map.svh"

package exec_pkg;

   // ------------------------------------------------------------------------
   // Instruction set handled by the execution unit
   // ------------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP,
      OP_LOWER_MEMORY_TO_WORKING,
      OP_SLEEP,
      OP_BUMP_MEMORY,
      OP_BUMP_MEMORY_TO_WORKING,
      OP_BRANCH_ABSOLUTE,
      OP_COPY_MEMORY_TO_WORKING,
      OP_COPY_IMMEDIATE,
      OP_COPY_WORKING_TO_MEMORY
   } op_t;

   // Decoded instruction word
   typedef struct packed {
      op_t                      op;
      logic [`EXEC_ADDR_W-1:0]  addr;
      logic [`EXEC_DATA_W-1:0]  imm;
      logic [`EXEC_PC_W-1:0]    target;
   } instr_t;

   // Status flags touched by this unit
   typedef struct packed {
      logic power_down_flag;
      logic watchdog_expiry_flag;
      logic zero;
   } status_t;

endpackage

// ---- src/exec_unit.sv ----
`timescale 1ns/100ps
`include "exec_map.svh"

// Operation
// [RULE_01] Decrement-to-working puts memory minus one in working register, sets zero.
// [RULE_02] Sleep halts execution and switches the system clock off.
// [RULE_03] Sleep keeps data memory, working register and program counter unchanged.
// [RULE_04] Sleep clears watchdog count and its prescaler.
// [RULE_05] Sleep sets power-down flag, clears expiry flag, touches no other flag.
// [RULE_06] In-place increment writes memory plus one back, updates zero flag.
// [RULE_07] Increment-to-working puts memory plus one in working register, sets zero.
// [RULE_08] Absolute branch loads program counter from instruction, no flag change.
// [RULE_09] Absolute branch takes two cycles, a dummy cycle follows.
// [RULE_10] Memory-to-working copy loads working register, no flag change.
// [RULE_11] Immediate load places constant in working register, no flag change.
// [RULE_12] Working-to-memory copy writes working register to memory, no flags.
module exec_unit (
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   input  wire logic                      instr_valid,
   input  wire exec_pkg::instr_t          instr,
   input  wire logic                      wake,
   input  wire logic [`EXEC_ADDR_W-1:0]   peek_addr,
   output logic                           instr_ready_q,
   output logic [`EXEC_DATA_W-1:0]        working_register_q,
   output logic [`EXEC_PC_W-1:0]          pc_q,
   output exec_pkg::status_t              status_q,
   output logic                           sys_clk_en_q,
   output logic                           dummy_cycle_q,
   output logic [`EXEC_DATA_W-1:0]        peek_data_q
);

   // ------------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------------
   logic [`EXEC_DATA_W-1:0]     mem_q [`EXEC_MEM_DEPTH];
   logic [`EXEC_DATA_W-1:0]     operand;
   logic [`EXEC_DATA_W-1:0]     dec_val;
   logic [`EXEC_DATA_W-1:0]     inc_val;
   logic                        fire;
   logic [`EXEC_WDT_PRE_W-1:0]  wdt_pre_q;
   logic [`EXEC_WDT_CNT_W-1:0]  wdt_cnt_q;
   logic                        pre_wrap;
   logic                        cnt_full;

   // Operand fetch and arithmetic
   assign fire    = instr_valid && instr_ready_q;
   assign operand = mem_q[instr.addr];
   assign dec_val = operand - `EXEC_DATA_W'(1);
   assign inc_val = operand + `EXEC_DATA_W'(1);

   // ------------------------------------------------------------------------
   // Data memory
   // ------------------------------------------------------------------------
   // Only the two writing instructions store; sleep leaves memory alone
   always_ff @(posedge core_clk) begin
      if (fire) begin
         unique case (instr.op)
            exec_pkg::OP_BUMP_MEMORY: begin
               mem_q[instr.addr] <= inc_val; // RULE_06
            end
            exec_pkg::OP_COPY_WORKING_TO_MEMORY: begin
               mem_q[instr.addr] <= working_register_q; // RULE_12
            end
            default: ;
         endcase
      end
   end

   // Registered look-at port into memory
   always_ff @(posedge core_clk) begin
      if (srst) begin
         peek_data_q <= `EXEC_WORK_RST;
      end else begin
         peek_data_q <= mem_q[peek_addr];
      end
   end

   // ------------------------------------------------------------------------
   // Working register
   // ------------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         working_register_q <= `EXEC_WORK_RST;
      end else if (fire) begin
         unique case (instr.op)
            exec_pkg::OP_LOWER_MEMORY_TO_WORKING: begin
               working_register_q <= dec_val; // RULE_01
            end
            exec_pkg::OP_BUMP_MEMORY_TO_WORKING: begin
               working_register_q <= inc_val; // RULE_07
            end
            exec_pkg::OP_COPY_MEMORY_TO_WORKING: begin
               working_register_q <= operand; // RULE_10
            end
            exec_pkg::OP_COPY_IMMEDIATE: begin
               working_register_q <= instr.imm; // RULE_11
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Zero flag
   // ------------------------------------------------------------------------
   // Only the three arithmetic instructions touch it
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_q.zero <= 1'b0;
      end else if (fire) begin
         unique case (instr.op)
            exec_pkg::OP_LOWER_MEMORY_TO_WORKING: begin
               status_q.zero <= (dec_val == '0); // RULE_01
            end
            exec_pkg::OP_BUMP_MEMORY,
            exec_pkg::OP_BUMP_MEMORY_TO_WORKING: begin
               status_q.zero <= (inc_val == '0); // RULE_06 RULE_07
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Program counter and branch sequencing
   // ------------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pc_q <= `EXEC_PC_RST;
      end else if (fire) begin
         if (instr.op == exec_pkg::OP_BRANCH_ABSOLUTE) begin
            pc_q <= instr.target; // RULE_08
         end else if (instr.op != exec_pkg::OP_SLEEP) begin // RULE_03
            pc_q <= pc_q + `EXEC_PC_W'(1);
         end
      end
   end

   // Dummy cycle inserted after a branch while the new address loads
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dummy_cycle_q <= 1'b0;
      end else begin
         dummy_cycle_q <= fire && (instr.op == exec_pkg::OP_BRANCH_ABSOLUTE); // RULE_09
      end
   end

   // ------------------------------------------------------------------------
   // Halt and system clock control
   // ------------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sys_clk_en_q <= 1'b1;
      end else if (fire && instr.op == exec_pkg::OP_SLEEP) begin
         sys_clk_en_q <= 1'b0; // RULE_02
      end else if (wake) begin
         sys_clk_en_q <= 1'b1;
      end
   end

   // Ready drops for the branch dummy cycle and while halted
   always_ff @(posedge core_clk) begin
      if (srst) begin
         instr_ready_q <= 1'b1;
      end else if (fire && instr.op == exec_pkg::OP_SLEEP) begin
         instr_ready_q <= 1'b0; // RULE_02
      end else if (fire && instr.op == exec_pkg::OP_BRANCH_ABSOLUTE) begin
         instr_ready_q <= 1'b0; // RULE_09
      end else if (!sys_clk_en_q) begin
         instr_ready_q <= wake;
      end else begin
         instr_ready_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // Watchdog timer
   // ------------------------------------------------------------------------
   assign pre_wrap = &wdt_pre_q;
   assign cnt_full = &wdt_cnt_q;

   // Prescaler and count run only while the system clock is on
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wdt_pre_q <= '0;
         wdt_cnt_q <= '0;
      end else if (fire && instr.op == exec_pkg::OP_SLEEP) begin
         wdt_pre_q <= '0; // RULE_04
         wdt_cnt_q <= '0; // RULE_04
      end else if (sys_clk_en_q) begin
         wdt_pre_q <= wdt_pre_q + `EXEC_WDT_PRE_W'(1);
         if (pre_wrap) begin
            wdt_cnt_q <= wdt_cnt_q + `EXEC_WDT_CNT_W'(1);
         end
      end
   end

   // Power-down and expiry flags; sleep writes both, the watchdog also sets the expiry flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_q.power_down_flag      <= 1'b0;
         status_q.watchdog_expiry_flag <= 1'b0;
      end else if (fire && instr.op == exec_pkg::OP_SLEEP) begin
         status_q.power_down_flag      <= 1'b1; // RULE_05
         status_q.watchdog_expiry_flag <= 1'b0; // RULE_05
      end else if (sys_clk_en_q && pre_wrap && cnt_full) begin
         status_q.watchdog_expiry_flag <= 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   property p_lower_to_working;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_LOWER_MEMORY_TO_WORKING
      |=> working_register_q == $past(operand) - 8'h01
          && status_q.zero == (working_register_q == 8'h00);
   endproperty
   a_lower_to_working: assert property (p_lower_to_working) // RULE_01
      else $error("decrement to working wrong");
   property p_sleep_halts;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_SLEEP && !wake
      |=> !sys_clk_en_q && !instr_ready_q && pc_q == $past(pc_q);
   endproperty
   a_sleep_halts: assert property (p_sleep_halts) // RULE_02
      else $error("sleep did not halt");
   property p_sleep_keeps;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_SLEEP
      |=> working_register_q == $past(working_register_q)
          && status_q.zero == $past(status_q.zero)
          && mem_q[$past(instr.addr)] == $past(operand);
   endproperty
   a_sleep_keeps: assert property (p_sleep_keeps) // RULE_03
      else $error("sleep altered state");
   property p_sleep_wdt;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_SLEEP
      |=> wdt_pre_q == 8'h00 && wdt_cnt_q == 8'h00;
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) // RULE_04
      else $error("watchdog not cleared by sleep");
   property p_sleep_flags;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_SLEEP
      |=> status_q.power_down_flag && !status_q.watchdog_expiry_flag;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) // RULE_05
      else $error("sleep flags wrong");
   property p_bump_memory;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_BUMP_MEMORY
      |=> mem_q[$past(instr.addr)] == $past(operand) + 8'h01
          && working_register_q == $past(working_register_q);
   endproperty
   a_bump_memory: assert property (p_bump_memory) // RULE_06
      else $error("in place increment wrong");
   property p_bump_to_working;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_BUMP_MEMORY_TO_WORKING
      |=> working_register_q == $past(operand) + 8'h01
          && mem_q[$past(instr.addr)] == $past(operand);
   endproperty
   a_bump_to_working: assert property (p_bump_to_working) // RULE_07
      else $error("increment to working wrong");
   property p_branch;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_BRANCH_ABSOLUTE
      |=> pc_q == $past(instr.target) && $stable(status_q)
          && dummy_cycle_q && !instr_ready_q ##1 instr_ready_q;
   endproperty
   a_branch: assert property (p_branch) // RULE_08 RULE_09
      else $error("branch sequencing wrong");
   property p_copy_to_working;
      @(posedge core_clk) disable iff (srst)
      fire && (instr.op == exec_pkg::OP_COPY_MEMORY_TO_WORKING
               || instr.op == exec_pkg::OP_COPY_IMMEDIATE)
      |=> working_register_q == $past(instr.op ==
             exec_pkg::OP_COPY_IMMEDIATE ? instr.imm : operand)
          && status_q.zero == $past(status_q.zero)
          && status_q.power_down_flag == $past(status_q.power_down_flag);
   endproperty
   a_copy_to_working: assert property (p_copy_to_working) // RULE_10 RULE_11
      else $error("copy to working wrong");
   property p_copy_to_memory;
      @(posedge core_clk) disable iff (srst)
      fire && instr.op == exec_pkg::OP_COPY_WORKING_TO_MEMORY
      |=> mem_q[$past(instr.addr)] == $past(working_register_q)
          && status_q.zero == $past(status_q.zero);
   endproperty
   a_copy_to_memory: assert property (p_copy_to_memory) // RULE_12
      else $error("copy to memory wrong");

endmodule

// ---- testbench/test_mcu_memory_acc_jump_halt_ops.sv ----
`timescale 1ns/100ps
`include "exec_map.svh"

module test_mcu_memory_acc_jump_halt_ops;

   // ------------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------------
   logic                        core_clk;
   logic                        srst;
   logic                        instr_valid;
   exec_pkg::instr_t            instr;
   logic                        wake;
   logic [`EXEC_ADDR_W-1:0]     peek_addr;
   logic                        instr_ready_q;
   logic [`EXEC_DATA_W-1:0]     working_register_q;
   logic [`EXEC_PC_W-1:0]       pc_q;
   exec_pkg::status_t           status_q;
   logic                        sys_clk_en_q;
   logic                        dummy_cycle_q;
   logic [`EXEC_DATA_W-1:0]     peek_data_q;
   int                          n_errors;
   int                          n_tests;
   int                          cycles;
   logic [`EXEC_PC_W-1:0]       pc_e;
   logic                        z_e;

   exec_unit uut (
      .core_clk           (core_clk),
      .srst               (srst),
      .instr_valid        (instr_valid),
      .instr              (instr),
      .wake               (wake),
      .peek_addr          (peek_addr),
      .instr_ready_q      (instr_ready_q),
      .working_register_q (working_register_q),
      .pc_q               (pc_q),
      .status_q           (status_q),
      .sys_clk_en_q       (sys_clk_en_q),
      .dummy_cycle_q      (dummy_cycle_q),
      .peek_data_q        (peek_data_q)
   );

   // 50 MHz clock
   always #10 core_clk = ~core_clk;

   // Cut a hung run short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 70000) begin
         n_errors++;
         close_out();
      end
   end

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Offer one instruction, hold it until taken, check the program counter
   task automatic issue(input exec_pkg::op_t o, input logic [7:0] a,
                        input logic [7:0] i, input logic [10:0] t);
      int k;
      k = 0;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr       <= '{op: o, addr: a, imm: i, target: t};
      do begin
         @(posedge core_clk);
         k++;
      end while (instr_ready_q !== 1'b1 && k < 20);
      instr_valid <= 1'b0;
      #1;
      if (o == exec_pkg::OP_BRANCH_ABSOLUTE)
         pc_e = t;
      else if (o != exec_pkg::OP_SLEEP)
         pc_e = pc_e + 11'h001;
      chk("pc", 16'(pc_q), 16'(pc_e));
   endtask

   task automatic peek(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      peek_addr <= a;
      @(posedge core_clk);
      #1;
      d = peek_data_q;
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] v);
      issue(exec_pkg::OP_COPY_IMMEDIATE, 8'h00, v, 11'h000);
      issue(exec_pkg::OP_COPY_WORKING_TO_MEMORY, a, 8'h00, 11'h000);
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------------
   // Copies: immediate, to memory, from memory; a zero value leaves flags
   task automatic t_copies;
      logic [7:0] d;
      issue(exec_pkg::OP_COPY_IMMEDIATE, 8'h00, 8'h5a, 11'h000);
      chk("working", 16'(working_register_q), 16'h005a);
      issue(exec_pkg::OP_COPY_WORKING_TO_MEMORY, 8'h10, 8'h00, 11'h000);
      peek(8'h10, d);
      chk("mem10", 16'(d), 16'h005a);
      chk("status", 16'(status_q), 16'h0000);
      issue(exec_pkg::OP_COPY_IMMEDIATE, 8'h00, 8'h00, 11'h000);
      chk("status", 16'(status_q), 16'h0000);
      issue(exec_pkg::OP_COPY_MEMORY_TO_WORKING, 8'h10, 8'h00, 11'h000);
      chk("working", 16'(working_register_q), 16'h005a);
      chk("status", 16'(status_q), 16'h0000);
   endtask

   // Decrement to working: memory stays, zero follows the result
   task automatic t_lower;
      logic [7:0] d;
      put(8'h20, 8'h01);
      issue(exec_pkg::OP_LOWER_MEMORY_TO_WORKING, 8'h20, 8'h00, 11'h000);
      chk("working", 16'(working_register_q), 16'h0000);
      chk("status", 16'(status_q), 16'h0001);
      peek(8'h20, d);
      chk("mem20", 16'(d), 16'h0001);
      issue(exec_pkg::OP_COPY_IMMEDIATE, 8'h00, 8'h77, 11'h000);
      chk("status", 16'(status_q), 16'h0001);
   endtask

   // Increment in place across the wrap, then increment to working
   task automatic t_bump;
      logic [7:0] d;
      put(8'h30, 8'hff);
      issue(exec_pkg::OP_BUMP_MEMORY, 8'h30, 8'h00, 11'h000);
      peek(8'h30, d);
      chk("mem30", 16'(d), 16'h0000);
      chk("status", 16'(status_q), 16'h0001);
      issue(exec_pkg::OP_BUMP_MEMORY, 8'h30, 8'h00, 11'h000);
      peek(8'h30, d);
      chk("mem30", 16'(d), 16'h0001);
      chk("status", 16'(status_q), 16'h0000);
      issue(exec_pkg::OP_BUMP_MEMORY_TO_WORKING, 8'h30, 8'h00, 11'h000);
      chk("working", 16'(working_register_q), 16'h0002);
      peek(8'h30, d);
      chk("mem30", 16'(d), 16'h0001);
      put(8'h31, 8'hff);
      issue(exec_pkg::OP_BUMP_MEMORY_TO_WORKING, 8'h31, 8'h00, 11'h000);
      chk("working", 16'(working_register_q), 16'h0000);
      chk("status", 16'(status_q), 16'h0001);
      z_e = 1'b1;
   endtask

   // Branch: new counter, one dummy cycle, flags kept, runs on from target
   task automatic t_branch;
      issue(exec_pkg::OP_BRANCH_ABSOLUTE, 8'h00, 8'h00, 11'h5a5);
      chk("dummy", 16'(dummy_cycle_q), 16'h0001);
      chk("ready", 16'(instr_ready_q), 16'h0000);
      chk("status", 16'(status_q), 16'(z_e));
      @(posedge core_clk);
      #1;
      chk("dummy", 16'(dummy_cycle_q), 16'h0000);
      chk("ready", 16'(instr_ready_q), 16'h0001);
      issue(exec_pkg::OP_NOP, 8'h00, 8'h00, 11'h000);
   endtask

   // Sleep: clock off, state kept, flags set and cleared, wake resumes
   task automatic t_sleep;
      logic [7:0] d;
      issue(exec_pkg::OP_COPY_IMMEDIATE, 8'h00, 8'h3c, 11'h000);
      // Let the watchdog run out so that sleep has an expiry flag to clear
      repeat (1 << (`EXEC_WDT_PRE_W + `EXEC_WDT_CNT_W)) @(posedge core_clk);
      #1;
      chk("status", 16'(status_q), {13'h0000, 2'h1, z_e});
      issue(exec_pkg::OP_SLEEP, 8'h00, 8'h00, 11'h000);
      chk("clk_en", 16'(sys_clk_en_q), 16'h0000);
      chk("ready", 16'(instr_ready_q), 16'h0000);
      chk("status", 16'(status_q), {13'h0000, 2'b10, z_e});
      chk("working", 16'(working_register_q), 16'h003c);
      repeat (6) @(posedge core_clk);
      #1;
      chk("ready", 16'(instr_ready_q), 16'h0000);
      @(posedge core_clk);
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      #1;
      chk("clk_en", 16'(sys_clk_en_q), 16'h0001);
      chk("ready", 16'(instr_ready_q), 16'h0001);
      peek(8'h30, d);
      chk("mem30", 16'(d), 16'h0001);
      chk("working", 16'(working_register_q), 16'h003c);
      chk("status", 16'(status_q), {13'h0000, 2'b10, z_e});
   endtask

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      core_clk    = 1'b0;
      srst        = 1'b1;
      instr_valid = 1'b0;
      instr       = '0;
      wake        = 1'b0;
      peek_addr   = 8'h00;
      n_errors    = 0;
      n_tests     = 0;
      cycles      = 0;
      pc_e        = 11'h000;
      z_e         = 1'b0;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      chk("ready", 16'(instr_ready_q), 16'h0001);
      chk("pc", 16'(pc_q), 16'h0000);
      t_copies();
      t_lower();
      t_bump();
      t_branch();
      t_sleep();
      close_out();
   end

endmodule
